// >>> src/twmbh_top.sv
// Purpose: two-wire master with event flag handshake and Avalon-MM registers
// Assumes: open-drain pins resolved outside; 40 MHz clk
// Notes: start, address/data bytes and stop; no arbitration or slave mode
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module twmbh_top (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // avalon-mm slave
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // two-wire bus pins
   input  wire twmbh_pkg::twmbh_pins_t pins_in,
   output twmbh_pkg::twmbh_pins_t      pins_out,
   output twmbh_pkg::twmbh_pins_t      pins_oe,
   // processor side
   input  wire logic                  global_irq_enable,
   output logic                       irq
);

   twmbh_pkg::twmbh_state_t state;
   twmbh_pkg::twmbh_ctrl_t  ctrl;
   twmbh_pkg::twmbh_pins_t  pins_s;
   logic [1:0]              pins_s_vec;
   logic                    ack;
   logic                    wr_lane;
   logic                    ctrl_wr;
   logic                    flag_clr;
   logic                    event_flag;
   logic                    go;
   logic                    launch;
   logic                    active;
   logic                    tick;
   logic                    advance;
   logic                    start_done;
   logic                    byte_done;
   logic                    stop_done;
   logic                    flag_set;
   logic [6:0]              div_cnt;
   logic [1:0]              phase;
   logic [3:0]              bit_cnt;
   logic [7:0]              address_data_shift_reg;
   logic [7:0]              serial_status_reg;
   logic [7:0]              event_code;
   logic                    sda_bit;
   logic                    is_addr;
   logic                    hold_sda;
   logic                    tx_bit;
   logic [1:0]              irq_status;
   logic [1:0]              irq_mask;
   logic [1:0]              irq_set;
   logic [1:0]              irq_clr;
   logic [31:0]             read_mux;
   twmbh_pkg::twmbh_state_t next_state;

   // pin inputs cross into clk domain
   twmbh_sync #(.W(2)) u_sync (
      .clk   (clk),
      .reset (reset),
      .din   ({pins_in.scl, pins_in.sda}),
      .dout  (pins_s_vec)
   );
   assign pins_s = pins_s_vec;

   // bus slave: one wait cycle, read data registered, write lands on release edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_lane         = avs_write & ack & avs_byteenable[0];
   assign ctrl_wr         = wr_lane & (avs_address == twmbh_pkg::ADDR_CTRL);
   assign flag_clr        = ctrl_wr & avs_writedata[twmbh_pkg::CTRL_FLAG];

   always_ff @(posedge clk) begin
      if (reset) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   always_comb begin
      read_mux = 32'h0000_0000;
      unique case (avs_address)
         twmbh_pkg::ADDR_CTRL: begin
            read_mux[twmbh_pkg::CTRL_FLAG]   = event_flag;
            read_mux[twmbh_pkg::CTRL_START]  = ctrl.start;
            read_mux[twmbh_pkg::CTRL_STOP]   = ctrl.stop;
            read_mux[twmbh_pkg::CTRL_ENABLE] = ctrl.enable;
            read_mux[twmbh_pkg::CTRL_IRQ_EN] = ctrl.irq_en;
         end
         twmbh_pkg::ADDR_STATUS:   read_mux[7:0] = serial_status_reg;
         twmbh_pkg::ADDR_DATA:     read_mux[7:0] = address_data_shift_reg;
         twmbh_pkg::ADDR_IRQ_STAT: read_mux[1:0] = irq_status;
         twmbh_pkg::ADDR_IRQ_MASK: read_mux[1:0] = irq_mask;
         default:                  read_mux      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack) begin
         avs_readdata <= read_mux;
      end
   end

   // serial_control_reg
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= twmbh_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl.start  <= avs_writedata[twmbh_pkg::CTRL_START];
         ctrl.stop   <= avs_writedata[twmbh_pkg::CTRL_STOP];
         ctrl.enable <= avs_writedata[twmbh_pkg::CTRL_ENABLE];
         ctrl.irq_en <= avs_writedata[twmbh_pkg::CTRL_IRQ_EN];
      end
   end

   // event flag: hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         event_flag <= 1'b0;
      end else if (flag_set) begin
         event_flag <= 1'b1;
      end else if (flag_clr) begin
         event_flag <= 1'b0;
      end
   end

   // a command is pending from the clearing write until launched
   always_ff @(posedge clk) begin
      if (reset) begin
         go <= 1'b0;
      end else if (flag_clr) begin
         go <= 1'b1;
      end else if (launch) begin
         go <= 1'b0;
      end
   end

   assign launch = go & ~event_flag & ctrl.enable & ((state == twmbh_pkg::S_IDLE) | (state == twmbh_pkg::S_HOLD));
   assign active = (state == twmbh_pkg::S_START) | (state == twmbh_pkg::S_BYTE) | (state == twmbh_pkg::S_STOP);

   // quarter-bit divider; a slave stretching scl holds phase 1
   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt <= 7'h00;
      end else if (!active || tick) begin
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   assign tick       = active & (div_cnt == twmbh_pkg::QUARTER_LAST);
   assign advance    = tick & ~((phase == 2'h1) & ~pins_s.scl);
   assign start_done = (state == twmbh_pkg::S_START) & advance & (phase == twmbh_pkg::PHASE_LAST);
   assign stop_done  = (state == twmbh_pkg::S_STOP) & advance & (phase == twmbh_pkg::PHASE_LAST);
   assign byte_done  = (state == twmbh_pkg::S_BYTE) & advance & (phase == twmbh_pkg::PHASE_LAST)
                       & (bit_cnt == twmbh_pkg::ACK_BIT);
   assign flag_set   = start_done | byte_done;

   always_comb begin
      next_state = state;
      if (launch) begin
         if (ctrl.start) begin
            next_state = twmbh_pkg::S_START;
         end else if (ctrl.stop) begin
            next_state = twmbh_pkg::S_STOP;
         end else if (state == twmbh_pkg::S_HOLD) begin
            next_state = twmbh_pkg::S_BYTE;
         end
      end else if (start_done || byte_done) begin
         next_state = twmbh_pkg::S_HOLD;
      end else if (stop_done) begin
         next_state = twmbh_pkg::S_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= twmbh_pkg::S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phase   <= 2'h0;
         bit_cnt <= 4'h0;
      end else if (launch) begin
         phase   <= 2'h0;
         bit_cnt <= 4'h0;
      end else if (advance) begin
         phase <= phase + 2'h1;
         if ((state == twmbh_pkg::S_BYTE) && (phase == twmbh_pkg::PHASE_LAST)) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end
   end

   // address_data_shift_reg: software loads it in any state except S_BYTE
   always_ff @(posedge clk) begin
      if (reset) begin
         address_data_shift_reg <= twmbh_pkg::SHIFT_RESET;
      end else if (wr_lane && (avs_address == twmbh_pkg::ADDR_DATA) && (state != twmbh_pkg::S_BYTE)) begin
         address_data_shift_reg <= avs_writedata[7:0];
      end else if ((state == twmbh_pkg::S_BYTE) && advance && (phase == twmbh_pkg::PHASE_LAST)
                   && (bit_cnt != twmbh_pkg::ACK_BIT)) begin
         address_data_shift_reg <= {address_data_shift_reg[6:0], sda_bit};
      end
   end

   // sda sampled at the end of the high time; in the ack slot low means acknowledged
   always_ff @(posedge clk) begin
      if (reset) begin
         sda_bit <= 1'b1;
      end else if ((state == twmbh_pkg::S_BYTE) && advance && (phase == 2'h2)) begin
         sda_bit <= pins_s.sda;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         is_addr  <= 1'b0;
         hold_sda <= 1'b0;
      end else if (start_done) begin
         is_addr  <= 1'b1;
         hold_sda <= 1'b1;
      end else if (byte_done) begin
         is_addr  <= 1'b0;
         hold_sda <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         event_code <= twmbh_pkg::CODE_NO_INFO;
      end else if (start_done) begin
         event_code <= twmbh_pkg::CODE_START;
      end else if (byte_done && is_addr) begin
         event_code <= sda_bit ? twmbh_pkg::CODE_ADDR_NACK : twmbh_pkg::CODE_ADDR_ACK;
      end else if (byte_done) begin
         event_code <= sda_bit ? twmbh_pkg::CODE_DATA_NACK : twmbh_pkg::CODE_DATA_ACK;
      end
   end

   // status follows the flag one cycle late
   always_ff @(posedge clk) begin
      if (reset) begin
         serial_status_reg <= twmbh_pkg::CODE_NO_INFO;
      end else begin
         serial_status_reg <= event_flag ? event_code : twmbh_pkg::CODE_NO_INFO;
      end
   end

   // open-drain drive; oe high pulls the line low
   assign tx_bit = (bit_cnt == twmbh_pkg::ACK_BIT) ? 1'b1 : address_data_shift_reg[7];
   assign pins_out = '0;

   always_comb begin
      pins_oe = '0;
      unique case (state)
         twmbh_pkg::S_IDLE: begin
            pins_oe = '0;
         end
         twmbh_pkg::S_START: begin
            pins_oe.scl = (phase == 2'h0) | (phase == twmbh_pkg::PHASE_LAST);
            pins_oe.sda = phase[1];
         end
         twmbh_pkg::S_BYTE: begin
            pins_oe.scl = (phase == 2'h0) | (phase == twmbh_pkg::PHASE_LAST);
            pins_oe.sda = ~tx_bit;
         end
         twmbh_pkg::S_STOP: begin
            pins_oe.scl = (phase == 2'h0);
            pins_oe.sda = ~phase[1];
         end
         twmbh_pkg::S_HOLD: begin
            pins_oe.scl = 1'b1;
            pins_oe.sda = hold_sda;
         end
      endcase
   end

   // sticky interrupt status, write one to clear, set wins
   assign irq_set[twmbh_pkg::IRQ_EVENT] = flag_set;
   assign irq_set[twmbh_pkg::IRQ_NACK]  = byte_done & sda_bit;
   assign irq_clr = (wr_lane && (avs_address == twmbh_pkg::ADDR_IRQ_STAT)) ? avs_writedata[1:0] : 2'h0;

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_status <= twmbh_pkg::IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_mask <= twmbh_pkg::IRQ_RESET;
      end else if (wr_lane && (avs_address == twmbh_pkg::ADDR_IRQ_MASK)) begin
         irq_mask <= avs_writedata[1:0];
      end
   end

   // both enables gate every source so polling mode stays silent
   assign irq = global_irq_enable & ctrl.irq_en & (event_flag | (|(irq_status & irq_mask)));

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   flag_scl_low_a: assert property (event_flag |-> pins_oe.scl)
      else $error("scl released while event flag set");
   flag_hold_a: assert property (event_flag |-> state == twmbh_pkg::S_HOLD)
      else $error("bus operation running while event flag set");
   launch_start_a: assert property ((go && !event_flag && ctrl.enable && ctrl.start && (state == twmbh_pkg::S_IDLE
                                     || state == twmbh_pkg::S_HOLD)) |=> state == twmbh_pkg::S_START)
      else $error("start not launched after flag clear");
   flag_clear_a: assert property ((flag_clr && !flag_set) |=> !event_flag)
      else $error("flag not cleared by writing one");
   flag_keep_a: assert property ((ctrl_wr && !avs_writedata[twmbh_pkg::CTRL_FLAG] && event_flag)
                                 |=> event_flag)
      else $error("flag cleared by writing zero");
   start_event_a: assert property (start_done |=> event_flag && event_code == twmbh_pkg::CODE_START)
      else $error("start sent without start event");
   addr_event_a: assert property ((byte_done && is_addr) |=> event_flag && (event_code ==
                                  ($past(sda_bit) ? twmbh_pkg::CODE_ADDR_NACK : twmbh_pkg::CODE_ADDR_ACK)))
      else $error("wrong address event code");
   data_event_a: assert property ((byte_done && !is_addr) |=> event_flag && (event_code ==
                                  ($past(sda_bit) ? twmbh_pkg::CODE_DATA_NACK : twmbh_pkg::CODE_DATA_ACK)))
      else $error("wrong data event code");
   stop_quiet_a: assert property (stop_done |=> (!event_flag)[*2])
      else $error("event raised after stop");
   status_lag_a: assert property ($rose(event_flag) |-> serial_status_reg == twmbh_pkg::CODE_NO_INFO
                                  ##1 serial_status_reg == event_code)
      else $error("status not updated one cycle after flag");
   status_none_a: assert property (!$past(event_flag) |-> serial_status_reg == twmbh_pkg::CODE_NO_INFO)
      else $error("status not idle code while flag clear");
   irq_gate_a: assert property (!(global_irq_enable && ctrl.irq_en) |-> !irq)
      else $error("interrupt while enables clear");
   irq_event_a: assert property ((event_flag && global_irq_enable && ctrl.irq_en) |-> irq)
      else $error("flag with enables did not interrupt");

   start_seen_c: cover property (start_done);
   addr_nack_c: cover property (byte_done && is_addr && sda_bit);
   data_ack_c: cover property (byte_done && !is_addr && !sda_bit);
   stop_seen_c: cover property (stop_done);

endmodule

// >>> inc/twmbh_pkg.sv
// Purpose: constants and types of the two-wire master byte handshake
// Assumes: 40 MHz clk, Avalon-MM slave with byte addresses
// Notes: register offsets, bit positions, codes and counts live here; twmbh_top writes phase numbers 0 to 2 as literals
package twmbh_pkg;

   // timing: quarter of a 100 kHz bit cell
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          QUARTER_NS    = 2500;
   localparam int          QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0]  QUARTER_LAST  = 7'(QUARTER_CYC - 1);

   // register byte addresses
   localparam logic [4:0]  ADDR_CTRL     = 5'h00;
   localparam logic [4:0]  ADDR_STATUS   = 5'h04;
   localparam logic [4:0]  ADDR_DATA     = 5'h08;
   localparam logic [4:0]  ADDR_IRQ_STAT = 5'h0c;
   localparam logic [4:0]  ADDR_IRQ_MASK = 5'h10;

   // control register bit positions
   localparam int          CTRL_FLAG     = 7;
   localparam int          CTRL_START    = 5;
   localparam int          CTRL_STOP     = 4;
   localparam int          CTRL_ENABLE   = 2;
   localparam int          CTRL_IRQ_EN   = 0;

   // sticky interrupt bits
   localparam int          IRQ_W         = 2;
   localparam int          IRQ_EVENT     = 0;
   localparam int          IRQ_NACK      = 1;
   localparam logic [1:0]  IRQ_RESET     = 2'h0;

   // status codes
   localparam logic [7:0]  CODE_START     = 8'h10;
   localparam logic [7:0]  CODE_ADDR_ACK  = 8'h20;
   localparam logic [7:0]  CODE_ADDR_NACK = 8'h24;
   localparam logic [7:0]  CODE_DATA_ACK  = 8'h30;
   localparam logic [7:0]  CODE_DATA_NACK = 8'h34;
   localparam logic [7:0]  CODE_NO_INFO   = 8'hf8;

   // byte sequencing
   localparam logic [3:0]  ACK_BIT       = 4'h8;
   localparam logic [1:0]  PHASE_LAST    = 2'h3;
   localparam logic [7:0]  SHIFT_RESET   = 8'h00;

   typedef struct packed {
      logic start;
      logic stop;
      logic enable;
      logic irq_en;
   } twmbh_ctrl_t;

   localparam twmbh_ctrl_t CTRL_RESET    = '0;

   typedef struct packed {
      logic scl;
      logic sda;
   } twmbh_pins_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_START,
      S_BYTE,
      S_STOP,
      S_HOLD
   } twmbh_state_t;

endpackage

// >>> src/twmbh_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes: only the second stage may be read
`timescale 1ns/1ps
module twmbh_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta;

   // released bus lines idle high, so reset to ones
   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= '1;
         dout <= '1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// >>> bench/twmbh_slave_model.sv
// Purpose: behavioural two-wire slave facing the master under test
// Assumes: bench resolves both lines with pull-ups from all enables
// Notes: acks or nacks each byte on command; may stretch scl low after each fall,
// Notes: a stretch shorter than the master's own low time would go unseen
`timescale 1ns/1ps
module twmbh_slave_model (
   // bus lines
   input  wire logic        scl,
   input  wire logic        sda,
   output logic             scl_oe,
   output logic             sda_oe,
   // behaviour control
   input  wire logic        nack_addr,
   input  wire logic        nack_data,
   input  wire logic [15:0] stretch_ns,
   // observed traffic
   output logic [7:0]       last_byte,
   output logic [7:0]       stop_count
);
   logic [7:0] sh;
   int         bitn;
   logic       active, acking, first;

   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      last_byte = 8'h00;
      stop_count = 8'h00;
      sh = 8'h00;
      bitn = 0;
      active = 1'b0;
      acking = 1'b0;
      first = 1'b0;
   end

   // start or repeated start: the first byte after it is the address
   always @(negedge sda) if (scl === 1'b1) begin
      active = 1'b1;
      acking = 1'b0;
      first = 1'b1;
      bitn = 0;
      sda_oe = 1'b0;
   end

   always @(posedge sda) if (scl === 1'b1 && active) begin
      active = 1'b0;
      stop_count++;
   end

   always @(posedge scl) if (active && !acking && bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
   end

   // ack bit driven only while scl is low, so it never looks like a start or stop
   always @(negedge scl) if (active) begin
      if (acking) begin
         sda_oe = 1'b0;
         acking = 1'b0;
         bitn = 0;
         first = 1'b0;
      end else if (bitn == 8) begin
         last_byte = sh;
         sda_oe = ~(first ? nack_addr : nack_data);
         acking = 1'b1;
      end
      if (stretch_ns != 16'h0000) begin
         scl_oe = 1'b1;
         #(stretch_ns);
         scl_oe = 1'b0;
      end
   end
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench for the two-wire master byte handshake
// Assumes: 40 MHz clk, slave model on the far side, registers over avalon-mm
// Notes: two passes, all-ack then all-nack with slave clock stretching
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] FLAG = 8'h01 << twmbh_pkg::CTRL_FLAG;
   localparam logic [7:0] STA  = 8'h01 << twmbh_pkg::CTRL_START;
   localparam logic [7:0] STO  = 8'h01 << twmbh_pkg::CTRL_STOP;
   localparam logic [7:0] EN   = (8'h01 << twmbh_pkg::CTRL_ENABLE) | (8'h01 << twmbh_pkg::CTRL_IRQ_EN);

   logic                   clk, reset, avs_read, avs_write, avs_waitrequest, global_irq_enable, irq;
   logic [4:0]             avs_address;
   logic [31:0]            avs_writedata, avs_readdata, rnd, q;
   logic [3:0]             avs_byteenable;
   twmbh_pkg::twmbh_pins_t pins_in, pins_out, pins_oe;
   logic                   slv_scl_oe, slv_sda_oe, nack_addr, nack_data;
   logic [15:0]            stretch_ns;
   logic [7:0]             last_byte, stop_count, addr_w;
   int                     mismatches, tests_run;
   logic [7:0]             exp_q[$];
   logic [4:0]             regs[6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};

   assign pins_in = '{scl: ~(pins_oe.scl | slv_scl_oe), sda: ~(pins_oe.sda | slv_sda_oe)};

   twmbh_top u_twmbh_top (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins_in(pins_in),
      .pins_out(pins_out), .pins_oe(pins_oe), .global_irq_enable(global_irq_enable), .irq(irq));

   twmbh_slave_model u_twmbh_slave_model (.scl(pins_in.scl), .sda(pins_in.sda), .scl_oe(slv_scl_oe),
      .sda_oe(slv_sda_oe), .nack_addr(nack_addr), .nack_data(nack_data), .stretch_ns(stretch_ns),
      .last_byte(last_byte), .stop_count(stop_count));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // request held until waitrequest is sampled low at a rising edge; data taken at that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check(n < 20, 1'b1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // software polls the flag rather than relying on the interrupt
   task automatic wait_flag();
      int n;
      n = 0;
      q = 32'h0;
      while (q[twmbh_pkg::CTRL_FLAG] !== 1'b1 && n < 3000) begin
         bus(1'b0, twmbh_pkg::ADDR_CTRL, 8'h00, 4'hf);
         n++;
      end
      check(q[twmbh_pkg::CTRL_FLAG], 1'b1);
   endtask

   task automatic send_byte(input logic [7:0] b, input logic [7:0] code);
      bus(1'b1, twmbh_pkg::ADDR_DATA, b, 4'hf);
      bus(1'b1, twmbh_pkg::ADDR_CTRL, STA | EN, 4'hf);
      repeat (20) @(posedge clk);
      bus(1'b0, twmbh_pkg::ADDR_CTRL, 8'h00, 4'hf);
      check(q[twmbh_pkg::CTRL_FLAG], 1'b1);
      @(negedge clk);
      check(pins_oe.scl, 1'b1);
      exp_q.push_back(b);
      bus(1'b1, twmbh_pkg::ADDR_CTRL, FLAG | EN, 4'hf);
      wait_flag();
      check(last_byte, exp_q.pop_front());
      bus(1'b0, twmbh_pkg::ADDR_STATUS, 8'h00, 4'hf);
      check(q, code);
      bus(1'b0, twmbh_pkg::ADDR_DATA, 8'h00, 4'hf);
      check(q, b);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      $display("ERROR t=%0t watchdog expired", $time);
      mismatches++;
      end_of_test();
   end

   initial begin
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      global_irq_enable = 1'b0;
      nack_addr = 1'b0;
      nack_data = 1'b0;
      stretch_ns = 16'h0000;
      mismatches = 0;
      tests_run = 0;
      rnd = 32'h26166054;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      // reset values, the last offset is unmapped
      foreach (regs[i]) begin
         bus(1'b0, regs[i], 8'h00, 4'hf);
         check(q, (regs[i] == twmbh_pkg::ADDR_STATUS) ? 32'(twmbh_pkg::CODE_NO_INFO) : 32'h0);
      end
      // open-drain pins never drive a high level
      check(pins_out, 32'h0);
      for (int p = 0; p < 2; p++) begin
         rnd = lfsr(rnd);
         nack_addr <= (p == 1);
         nack_data <= (p == 1);
         global_irq_enable <= (p == 1);
         // stretch outlasts the master's own two low quarters so phase 1 really waits
         stretch_ns <= (p == 1) ? 16'd6000 + 16'(rnd[1:0]) * 16'd1500 : 16'h0000;
         bus(1'b1, twmbh_pkg::ADDR_CTRL, FLAG | STA | EN, 4'hf);
         wait_flag();
         bus(1'b0, twmbh_pkg::ADDR_STATUS, 8'h00, 4'hf);
         check(q, twmbh_pkg::CODE_START);
         @(negedge clk);
         check(pins_oe.scl, 1'b1);
         check(irq, p == 1);
         addr_w = {rnd[9:3], 1'b0};
         send_byte(addr_w, (p == 1) ? twmbh_pkg::CODE_ADDR_NACK : twmbh_pkg::CODE_ADDR_ACK);
         send_byte(rnd[23:16], (p == 1) ? twmbh_pkg::CODE_DATA_NACK : twmbh_pkg::CODE_DATA_ACK);
         bus(1'b0, twmbh_pkg::ADDR_IRQ_STAT, 8'h00, 4'hf);
         check(q, {30'h0, p == 1, 1'b1});
         bus(1'b1, twmbh_pkg::ADDR_CTRL, FLAG | STO | EN, 4'hf);
         // stop is four quarters of 100 cycles, plus any stretch still held from the last fall
         repeat (1000) @(posedge clk);
         bus(1'b0, twmbh_pkg::ADDR_CTRL, 8'h00, 4'hf);
         check(q[twmbh_pkg::CTRL_FLAG], 1'b0);
         check(stop_count, p + 1);
         bus(1'b0, twmbh_pkg::ADDR_STATUS, 8'h00, 4'hf);
         check(q, twmbh_pkg::CODE_NO_INFO);
         // mask write ignored without byte lane zero in the first pass
         bus(1'b1, twmbh_pkg::ADDR_IRQ_MASK, 8'h03, (p == 1) ? 4'hf : 4'h0);
         bus(1'b0, twmbh_pkg::ADDR_IRQ_MASK, 8'h00, 4'hf);
         check(q, (p == 1) ? 32'h3 : 32'h0);
         @(negedge clk);
         check(irq, p == 1);
         bus(1'b1, twmbh_pkg::ADDR_IRQ_STAT, 8'h03, 4'hf);
         @(negedge clk);
         check(irq, 1'b0);
         bus(1'b0, twmbh_pkg::ADDR_IRQ_STAT, 8'h00, 4'hf);
         check(q, 32'h0);
      end
      end_of_test();
   end
endmodule
